// ==== core/sdwc_pkg.sv ====
// constants and register map shared by both ends of the dual wiper spi link, and the host phase type.
// assumes a 250 mhz system clock on each end and spi mode 0 on the link.
package sdwc_pkg;

	// system clock
	localparam int CLK_PERIOD_NS = 4;

	// link timing seen from the host (least times, rounded up to whole cycles)
	localparam int SCK_HALF_NS     = 100;
	localparam int LEAD_NS         = 250;
	localparam int LAG_NS          = 250;
	localparam int DESELECT_NS     = 2000;
	localparam int SCK_HALF_CYC    = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEAD_CYC        = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LAG_CYC         = (LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DESELECT_CYC    = (DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 10;

	// register map
	localparam logic [4:0] ADDR_WIPER0 = 5'h00;
	localparam logic [4:0] ADDR_WIPER1 = 5'h01;
	localparam logic [4:0] ADDR_ACR    = 5'h10;

	// reset values and fields
	localparam logic [7:0] WIPER_RESET    = 8'h40;
	localparam logic [7:0] ACR_RESET      = 8'h40;
	localparam logic [7:0] WIPER_MASK     = 8'h7F;
	localparam logic [7:0] ACR_WRITE_MASK = 8'h42;
	localparam int         ACR_SHUTDOWN_N_BIT_BIT   = 6;
	localparam int         ACR_OD_BIT     = 1;

	// opcode_field values
	localparam logic [2:0] OP_NOP      = 3'h0;
	localparam logic [2:0] OP_ACR_RD   = 3'h1;
	localparam logic [2:0] OP_ACR_WR   = 3'h3;
	localparam logic [2:0] OP_ADDR_RD  = 3'h4;
	localparam logic [2:0] OP_ADDR_WR  = 3'h6;
	localparam logic [2:0] RSP_ECHO_OP = 3'h7;

	// frame layout
	localparam logic [2:0] BYTE_ECHO  = 3'h2;
	localparam logic [2:0] BYTE_VALUE = 3'h3;
	localparam logic [2:0] BYTE_SAT   = 3'h4;
	localparam logic [5:0] WRITE_BITS = 6'h10;
	localparam logic [5:0] READ_BITS  = 6'h20;

	typedef enum {
		SDWC_H_IDLE,
		SDWC_H_LEAD,
		SDWC_H_LOW,
		SDWC_H_HIGH,
		SDWC_H_LAG,
		SDWC_H_GAP
	} sdwc_host_phase_t;

endpackage : sdwc_pkg

// ==== core/sdwc_spi_if.sv ====
// link wires between host and potentiometer device.
// assumes an external pull-up on the data output; released line reads as one.
`timescale 1ns/1ns
interface sdwc_spi_if;
	logic sck;
	logic cs_n;
	logic sdi;
	logic sdo_drv;
	logic sdo_oe_n;
	logic sdo;

	// released line is pulled high, covers both standby and open drain
	assign sdo = sdo_oe_n ? 1'b1 : sdo_drv;

	modport device (
		input  sck,
		input  cs_n,
		input  sdi,
		output sdo_drv,
		output sdo_oe_n
	);

	modport host (
		output sck,
		output cs_n,
		output sdi,
		input  sdo
	);
endinterface : sdwc_spi_if

// ==== core/sdwc_device.sv ====
// potentiometer device end: spi mode 0 slave holding two wiper registers and
// the access control register. assumes the host keeps the link slow against
// clk_in; every link input is synchronised, and the sck and cs_n edges are found in clk_in.
`timescale 1ns/1ns

module sdwc_device
	import sdwc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	sdwc_spi_if.device      spi,
	output logic      [7:0] wiper0_position_out,
	output logic      [7:0] wiper1_position_out,
	output logic            shutdown_n_out,
	output logic            open_drain_out
);

	typedef struct packed {
		logic [1:0] sck_sync;
		logic       sck_last;
		logic [1:0] cs_sync;
		logic       cs_last;
		logic [1:0] sdi_sync;
		logic [7:0] shift_in;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic       odd_byte;
		logic [7:0] instr;
		logic [7:0] wdata;
		logic       have_data;
		logic [4:0] rd_addr;
		logic       rd_pend;
		logic [7:0] shift_out;
		logic       sdo_drv;
		logic       sdo_oe_n;
		logic [7:0] wiper0;
		logic [7:0] wiper1;
		logic [7:0] access_control;
	} sdwc_dev_state_t;

	sdwc_dev_state_t s;
	sdwc_dev_state_t next_s;

	function automatic logic [7:0] sdwc_read_reg(
		input logic [4:0] addr,
		input logic [7:0] w0,
		input logic [7:0] w1,
		input logic [7:0] access_control
	);
		logic [7:0] value;
		value = 8'h00;
		if (addr == ADDR_WIPER0) begin
			value = w0;
		end else if (addr == ADDR_WIPER1) begin
			value = w1;
		end else if (addr == ADDR_ACR) begin
			value = access_control;
		end
		return value;
	endfunction : sdwc_read_reg

	logic       sck;
	logic       cs_n;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_fall;
	logic       cs_rise;
	logic [7:0] rx_byte;
	logic [2:0] wr_op;
	logic [4:0] wr_addr;
	logic       resp_phase;
	logic       out_bit;

	always_comb begin
		next_s = s;
		// first sync stage is read only by the second
		next_s.sck_sync = {s.sck_sync[0], spi.sck};
		next_s.cs_sync  = {s.cs_sync[0], spi.cs_n};
		next_s.sdi_sync = {s.sdi_sync[0], spi.sdi};
		next_s.sck_last = s.sck_sync[1];
		next_s.cs_last  = s.cs_sync[1];

		sck      = s.sck_sync[1];
		cs_n     = s.cs_sync[1];
		sck_rise = sck & ~s.sck_last;
		sck_fall = ~sck & s.sck_last;
		cs_fall  = ~cs_n & s.cs_last;
		cs_rise  = cs_n & ~s.cs_last;
		rx_byte  = {s.shift_in[6:0], s.sdi_sync[1]};
		wr_op    = s.instr[7:5];
		wr_addr  = s.instr[4:0];

		if (cs_fall) begin
			next_s.bit_cnt   = 3'h0;
			next_s.byte_cnt  = 3'h0;
			next_s.odd_byte  = 1'b0;
			next_s.have_data = 1'b0;
			next_s.rd_pend   = 1'b0;
			next_s.shift_out = 8'h00;
		end else if (cs_rise) begin
			// partial byte is dropped, only whole data bytes count
			next_s.bit_cnt   = 3'h0;
			next_s.have_data = 1'b0;
			next_s.rd_pend   = 1'b0;
			if (s.have_data) begin
				if (wr_op == OP_ACR_WR || (wr_op == OP_ADDR_WR && wr_addr == ADDR_ACR)) begin
					next_s.access_control = s.wdata & ACR_WRITE_MASK;
				end else if (wr_op == OP_ADDR_WR && wr_addr == ADDR_WIPER0) begin
					next_s.wiper0 = s.wdata & WIPER_MASK;
				end else if (wr_op == OP_ADDR_WR && wr_addr == ADDR_WIPER1) begin
					next_s.wiper1 = s.wdata & WIPER_MASK;
				end
			end
		end else if (~cs_n && sck_rise) begin
			next_s.shift_in = rx_byte;
			next_s.bit_cnt  = s.bit_cnt + 3'h1;
			if (s.bit_cnt == 3'h7) begin
				next_s.odd_byte = ~s.odd_byte;
				if (s.byte_cnt != BYTE_SAT) begin
					next_s.byte_cnt = s.byte_cnt + 3'h1;
				end
				if (s.byte_cnt == 3'h0) begin
					next_s.instr = rx_byte;
					if (rx_byte[7:5] == OP_ACR_RD) begin
						next_s.rd_addr = ADDR_ACR;
						next_s.rd_pend = 1'b1;
					end else if (rx_byte[7:5] == OP_ADDR_RD) begin
						next_s.rd_addr = rx_byte[4:0];
						next_s.rd_pend = 1'b1;
					end
				end else if (s.odd_byte) begin
					// more data bytes: the last whole one in an odd byte position wins
					next_s.wdata     = rx_byte;
					next_s.have_data = 1'b1;
				end
			end
		end else if (~cs_n && sck_fall) begin
			if (s.bit_cnt == 3'h0 && s.byte_cnt == BYTE_ECHO) begin
				next_s.shift_out = {RSP_ECHO_OP, s.rd_addr};
			end else if (s.bit_cnt == 3'h0 && s.byte_cnt == BYTE_VALUE) begin
				next_s.shift_out = sdwc_read_reg(s.rd_addr, s.wiper0, s.wiper1, s.access_control);
			end else begin
				next_s.shift_out = {s.shift_out[6:0], 1'b0};
			end
		end

		// drive only while answering a read and selected; the line moves only on
		// sck falls or at deselect, so it never changes while the host samples it
		resp_phase = next_s.rd_pend &
			(next_s.byte_cnt == BYTE_ECHO || next_s.byte_cnt == BYTE_VALUE);
		out_bit = next_s.shift_out[7];
		if (cs_n) begin
			next_s.sdo_drv  = 1'b0;
			next_s.sdo_oe_n = 1'b1;
		end else if (~sck_fall) begin
			next_s.sdo_drv  = s.sdo_drv;
			next_s.sdo_oe_n = s.sdo_oe_n;
		end else if (~resp_phase) begin
			next_s.sdo_drv  = 1'b0;
			next_s.sdo_oe_n = 1'b1;
		end else if (s.access_control[ACR_OD_BIT]) begin
			// open drain: a one is left to the pull-up
			next_s.sdo_drv  = 1'b0;
			next_s.sdo_oe_n = out_bit;
		end else begin
			next_s.sdo_drv  = out_bit;
			next_s.sdo_oe_n = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s           <= '0;
			s.sck_sync  <= 2'h0;
			s.cs_sync   <= 2'h3;
			s.cs_last   <= 1'b1;
			s.sdo_oe_n  <= 1'b1;
			s.wiper0    <= WIPER_RESET;
			s.wiper1    <= WIPER_RESET;
			s.access_control       <= ACR_RESET;
		end else begin
			s <= next_s;
		end
	end

	// wiper values stay stored through shutdown; the analog side gates them
	assign wiper0_position_out = s.wiper0;
	assign wiper1_position_out = s.wiper1;
	assign shutdown_n_out      = s.access_control[ACR_SHUTDOWN_N_BIT_BIT];
	assign open_drain_out      = s.access_control[ACR_OD_BIT];
	assign spi.sdo_drv         = s.sdo_drv;
	assign spi.sdo_oe_n        = s.sdo_oe_n;

endmodule : sdwc_device

// ==== core/sdwc_host.sv ====
// host end: spi mode 0 master that runs one write or one read frame per request.
// assumes the device end joins on sdwc_spi_if; the host makes sck by division.
`timescale 1ns/1ns
module sdwc_host
	import sdwc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	sdwc_spi_if.host        spi,
	input  wire logic       req_valid_in,
	input  wire logic       req_write_in,
	input  wire logic [4:0] req_addr_in,
	input  wire logic [7:0] req_data_in,
	output logic            req_ready_out,
	output logic            rsp_valid_out,
	output logic      [7:0] rsp_echo_out,
	output logic      [7:0] rsp_data_out
);

	typedef struct packed {
		sdwc_host_phase_t   phase;
		logic [TIMER_W-1:0] timer;
		logic [31:0]        tx;
		logic [31:0]        rx;
		logic [5:0]         bits_left;
		logic               is_read;
		logic [1:0]         sdo_sync;
		logic               sck;
		logic               cs_n;
		logic               sdi;
		logic               ready;
		logic               rsp_valid;
		logic [7:0]         rsp_echo;
		logic [7:0]         rsp_data;
	} sdwc_host_state_t;

	sdwc_host_state_t s;
	sdwc_host_state_t next_s;

	always_comb begin
		next_s           = s;
		next_s.sdo_sync  = {s.sdo_sync[0], spi.sdo};
		next_s.rsp_valid = 1'b0;
		if (s.timer != '0) begin
			next_s.timer = s.timer - 1'b1;
		end
		case (s.phase)
			SDWC_H_IDLE: begin
				if (req_valid_in) begin
					// cs falls first, so the device sees its frame start
					next_s.is_read = ~req_write_in;
					if (req_write_in) begin
						next_s.tx        = {OP_ADDR_WR, req_addr_in, req_data_in, 16'h0000};
						next_s.bits_left = WRITE_BITS;
					end else begin
						next_s.tx        = {OP_ADDR_RD, req_addr_in, 8'h00, OP_NOP, 5'h00, 8'h00};
						next_s.bits_left = READ_BITS;
					end
					next_s.sdi   = next_s.tx[31];
					next_s.cs_n  = 1'b0;
					next_s.ready = 1'b0;
					next_s.timer = TIMER_W'(LEAD_CYC - 1);
					next_s.phase = SDWC_H_LEAD;
				end
			end
			SDWC_H_LEAD, SDWC_H_LOW: begin
				if (s.timer == '0) begin
					// rising edge: sample the device's bit
					next_s.sck   = 1'b1;
					next_s.rx    = {s.rx[30:0], s.sdo_sync[1]};
					next_s.timer = TIMER_W'(SCK_HALF_CYC - 1);
					next_s.phase = SDWC_H_HIGH;
				end
			end
			SDWC_H_HIGH: begin
				if (s.timer == '0) begin
					next_s.sck       = 1'b0;
					next_s.bits_left = s.bits_left - 6'h01;
					if (s.bits_left == 6'h01) begin
						next_s.timer = TIMER_W'(LAG_CYC - 1);
						next_s.phase = SDWC_H_LAG;
					end else begin
						// falling edge: next bit, msb first
						next_s.tx    = {s.tx[30:0], 1'b0};
						next_s.sdi   = s.tx[30];
						next_s.timer = TIMER_W'(SCK_HALF_CYC - 1);
						next_s.phase = SDWC_H_LOW;
					end
				end
			end
			SDWC_H_LAG: begin
				if (s.timer == '0) begin
					next_s.cs_n      = 1'b1;
					next_s.sdi       = 1'b0;
					next_s.rsp_valid = 1'b1;
					next_s.rsp_echo  = s.is_read ? s.rx[15:8] : 8'h00;
					next_s.rsp_data  = s.is_read ? s.rx[7:0] : 8'h00;
					next_s.timer     = TIMER_W'(DESELECT_CYC - 1);
					next_s.phase     = SDWC_H_GAP;
				end
			end
			SDWC_H_GAP: begin
				if (s.timer == '0) begin
					next_s.ready = 1'b1;
					next_s.phase = SDWC_H_IDLE;
				end
			end
			default: begin
				next_s.phase = SDWC_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s          <= '0;
			s.phase    <= SDWC_H_IDLE;
			s.sdo_sync <= 2'h3;
			s.cs_n     <= 1'b1;
			s.ready    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign spi.sck       = s.sck;
	assign spi.cs_n      = s.cs_n;
	assign spi.sdi       = s.sdi;
	assign req_ready_out = s.ready;
	assign rsp_valid_out = s.rsp_valid;
	assign rsp_echo_out  = s.rsp_echo;
	assign rsp_data_out  = s.rsp_data;

endmodule : sdwc_host

// ==== verification/sdwc_link_properties.sv ====
// link checks on the wires between the host end and the device end.
// assumes it sits beside the joining interface, clocked by the shared clk_in.
`timescale 1ns/1ns
module sdwc_link_properties
	import sdwc_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo_drv,
	input wire logic sdo_oe_n,
	input wire logic sdo
);
	logic [5:0] bits;
	logic       sck_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	// sck rises seen in the current frame
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bits <= 6'h00;
			sck_q <= 1'h0;
		end else begin
			sck_q <= sck;
			if (cs_n)
				bits <= 6'h00;
			else if (sck && !sck_q)
				bits <= bits + 6'h01;
		end
	end

	sequence s_sck_low;
		!sck [*8];
	endsequence
	sequence s_deselected;
		cs_n [*8];
	endsequence

	sck_idle_low_a: assert property (cs_n |-> !sck)
		else $error("sck high while deselected");
	select_lead_a: assert property ($fell(cs_n) |-> s_sck_low)
		else $error("sck rose too soon after select");
	deselect_gap_a: assert property ($rose(cs_n) |-> s_deselected)
		else $error("select gap too short");
	sdi_held_a: assert property ($rose(sck) |-> $stable(sdi) [*8])
		else $error("sdi moved near sck rise");
	sdo_held_a: assert property ($rose(sck) |-> $stable(sdo) [*8])
		else $error("sdo moved near sck rise");
	frame_length_a: assert property ($rose(cs_n) |-> bits == 6'h10 || bits == 6'h20)
		else $error("frame not whole bytes");
	drive_window_a: assert property (!sdo_oe_n |-> bits >= 6'h10)
		else $error("sdo driven outside response");
	standby_release_a: assert property (cs_n [*6] |-> sdo_oe_n)
		else $error("sdo driven while deselected");
	echo_prefix_a: assert property ($rose(sck) && bits >= 6'h10 && bits < 6'h13 |-> sdo)
		else $error("echo prefix not ones");
	value_msb_a: assert property ($rose(sck) && bits == 6'h18 |-> !sdo)
		else $error("value top bit set");
	release_low_a: assert property (sdo_oe_n |-> !sdo_drv)
		else $error("drive value high while released");
endmodule : sdwc_link_properties

// ==== verification/spi_dual_wiper_control_tb_top.sv ====
// bench joining host and device ends; rows of host requests, then a reset test.
// assumes the package timings; sdi and sdo are watched on the wires too.
`timescale 1ns/1ns
module spi_dual_wiper_control_tb_top;
	import sdwc_pkg::*;
	typedef struct packed {
		logic w; logic [4:0] a; logic [7:0] d; logic [15:0] rsp; logic [15:0] wip; logic [1:0] ctl;
	} sdwc_row_t;
	logic        clk_in = 1'h0;
	logic        resetn_in = 1'h0;
	logic        req_valid = 1'h0;
	logic        req_write = 1'h0;
	logic [4:0]  req_addr = 5'h00;
	logic [7:0]  req_data = 8'h00;
	logic        req_ready, rsp_valid, sh_n, od;
	logic [7:0]  rsp_echo, rsp_data, w0, w1;
	logic [31:0] sdi_sh, sdo_sh;
	int          mismatches = 0;
	int          checked = 0;
	// w addr data {echo,value} {wiper0,wiper1} {shutdown_n,open_drain}
	sdwc_row_t rows [0:12] = '{
		{1'h0, 5'h00, 8'h00, 16'hE040, 16'h4040, 2'h2}, // defaults
		{1'h0, 5'h10, 8'h00, 16'hF040, 16'h4040, 2'h2},
		{1'h1, 5'h00, 8'hFF, 16'h0000, 16'h7F40, 2'h2},
		{1'h0, 5'h00, 8'h00, 16'hE07F, 16'h7F40, 2'h2},
		{1'h1, 5'h01, 8'h00, 16'h0000, 16'h7F00, 2'h2},
		{1'h0, 5'h01, 8'h00, 16'hE100, 16'h7F00, 2'h2},
		{1'h1, 5'h10, 8'hFF, 16'h0000, 16'h7F00, 2'h3},
		{1'h0, 5'h10, 8'h00, 16'hF042, 16'h7F00, 2'h3}, // open drain read
		{1'h1, 5'h10, 8'h00, 16'h0000, 16'h7F00, 2'h0}, // shutdown
		{1'h0, 5'h00, 8'h00, 16'hE07F, 16'h7F00, 2'h0},
		{1'h1, 5'h05, 8'h12, 16'h0000, 16'h7F00, 2'h0}, // unmapped
		{1'h0, 5'h05, 8'h00, 16'hE500, 16'h7F00, 2'h0},
		{1'h1, 5'h10, 8'h40, 16'h0000, 16'h7F00, 2'h2}
	};

	always #2 clk_in = ~clk_in;

	sdwc_spi_if i_sdwc_spi_if ();
	sdwc_host i_sdwc_host (.clk_in(clk_in), .resetn_in(resetn_in), .spi(i_sdwc_spi_if.host),
		.req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
		.req_data_in(req_data), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
		.rsp_echo_out(rsp_echo), .rsp_data_out(rsp_data));
	sdwc_device i_sdwc_device (.clk_in(clk_in), .resetn_in(resetn_in),
		.spi(i_sdwc_spi_if.device), .wiper0_position_out(w0), .wiper1_position_out(w1),
		.shutdown_n_out(sh_n), .open_drain_out(od));
	sdwc_link_properties i_sdwc_link_properties (.clk_in(clk_in), .resetn_in(resetn_in),
		.sck(i_sdwc_spi_if.sck), .cs_n(i_sdwc_spi_if.cs_n), .sdi(i_sdwc_spi_if.sdi),
		.sdo_drv(i_sdwc_spi_if.sdo_drv), .sdo_oe_n(i_sdwc_spi_if.sdo_oe_n),
		.sdo(i_sdwc_spi_if.sdo));

	// wire view at each sck rise, independent of both ends
	always @(posedge i_sdwc_spi_if.sck) begin
		sdi_sh <= {sdi_sh[30:0], i_sdwc_spi_if.sdi};
		sdo_sh <= {sdo_sh[30:0], i_sdwc_spi_if.sdo};
	end

	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'h1 && n < 4000) begin
			@(posedge clk_in);
			#1 n++;
		end
		req_valid = 1'h1;
		req_write = w;
		req_addr = a;
		req_data = d;
		@(posedge clk_in);
		#1 req_valid = 1'h0;
		n = 0;
		while (rsp_valid !== 1'h1 && n < 4000) begin
			@(posedge clk_in);
			#1 n++;
		end
		cmp("rsp_valid", 16'h0001, {15'h0, rsp_valid});
		cmp("ready in gap", 16'h0000, {15'h0, req_ready});
		// device updates a few cycles after select rises
		repeat (10) @(posedge clk_in);
		#1;
	endtask : xfer

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	initial begin
		#300000;
		mismatches++;
		$display("FAIL watchdog expected done seen running");
		end_of_test();
	end

	initial begin
		repeat (4) @(posedge clk_in);
		#1 resetn_in = 1'h1;
		for (int i = 0; i <= 12; i++) begin
			xfer(rows[i].w, rows[i].a, rows[i].d);
			if (rows[i].w) begin
				cmp("sdi write", {3'h6, rows[i].a, rows[i].d}, sdi_sh[15:0]);
			end else begin
				cmp("sdi read", {3'h4, rows[i].a, 8'h00}, sdi_sh[31:16]);
				cmp("sdo", rows[i].rsp, sdo_sh[15:0]);
				cmp("rsp", rows[i].rsp, {rsp_echo, rsp_data});
			end
			cmp("wipers", rows[i].wip, {w0, w1});
			cmp("control", {14'h0, rows[i].ctl}, {14'h0, sh_n, od});
			$display("row %0d done", i);
		end
		// reset in the middle of a write frame; the host must be idle to take it
		while (req_ready !== 1'h1) begin
			@(posedge clk_in);
			#1;
		end
		req_valid = 1'h1;
		req_write = 1'h1;
		req_addr = 5'h00;
		req_data = 8'h55;
		@(posedge clk_in);
		#1 req_valid = 1'h0;
		repeat (400) @(posedge clk_in);
		#1 resetn_in = 1'h0;
		repeat (4) @(posedge clk_in);
		#1 resetn_in = 1'h1;
		cmp("reset wipers", 16'h4040, {w0, w1});
		cmp("reset control", 16'h0002, {14'h0, sh_n, od});
		cmp("reset ready", 16'h0001, {15'h0, req_ready});
		xfer(1'h0, 5'h00, 8'h00);
		cmp("rsp after reset", 16'hE040, {rsp_echo, rsp_data});
		$display("reset test done");
		end_of_test();
	end
endmodule : spi_dual_wiper_control_tb_top
